/* File: logic/tco_timer.sv */
// eight-channel interval timer with per-channel pin output control
// assumes a one-cycle strobe register port, read data one cycle later
// Functional notes
// - counting and reload never depend on output value, enable or level.
// - master output mode ignores level, toggles pin from preloaded default.
// - slave output mode takes active level from the level bit.
// - level change alone never moves the pin; applies at next set/reset.
// - slave set from master interrupt delayed one count clock.
// - simultaneous set and reset: reset wins, set suppressed.
// - output value write only updates channels with output disabled.
// - enabled channels keep timer-driven changes despite value writes.
// - interval mode only: start bit selects interrupt at start.
// - other modes: no start interrupt and no output change.
// - start bit 1: interrupt and toggle when counting begins.
// - start bit 0: silent start, interrupt after first full count.
// - interrupt period is count clock times reload value plus one.
// - square wave toggles every interrupt, 50% duty, double period.
// - counts down; loads reload value at first count clock after start.
// - at zero: interrupt, toggle and reload on next count clock.
// - reload value writable anytime, used from next count period.
// - mode 000 interval, trigger 000 software only, edge field 00.
// - clock select 00 a, 10 b; 01 c, 11 d only channels 1, 3.
// - split bit on 1, 3 gives 8-bit timer; lead bit 0 independent.
// - eight channels 0..7; only 0, 2, 4, 6 may lead.
// - slave level 0: master sets, slave resets; level 1 reversed.
// - output value register always reads current pin levels.
`timescale 1ns/10ps
module tco_timer #(
  parameter int CNT_W = 16
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [tco_pkg::AW-1:0] addr,
  input wire logic [tco_pkg::DW-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [tco_pkg::DW-1:0] rd_data,
  output logic [tco_pkg::NCH-1:0] chan_pin_out,
  output logic [tco_pkg::NCH-1:0] chan_irq,
  output logic [tco_pkg::NCH-1:0] chan_running
);
  import tco_pkg::*;

  if (CNT_W != CW) begin : g_chk
    $error("counter width must be 16");
  end

  typedef struct packed {
    logic [NCH-1:0][15:0] mode;
    logic [NCH-1:0][15:0] reload;
    logic [NCH-1:0][15:0] count;
    logic [15:0] pre_cfg;
    logic [15:0] pre_cnt;
    logic [NCH-1:0] oe;
    logic [NCH-1:0] pol;
    logic [NCH-1:0] slv;
    logic [NCH-1:0] run;
    logic [NCH-1:0] pend;
    logic [NCH-1:0] irq;
    logic [NCH-1:0] cen;
    logic [DW-1:0] rdata;
  } tco_state_t;

  tco_state_t s;
  tco_state_t next_s;
  logic [3:0] pre_tick;
  logic [NCH-1:0] tick;
  logic [15:0] cmask;
  logic [2:0] rgn;
  logic [2:0] idx;
  logic aligned;
  logic outval_wr;

  // ==========================================================
  // helpers
  function automatic logic [15:0] div_mask(input logic [3:0] d);
    div_mask = (16'h0001 << d) - 16'h0001;
  endfunction

  function automatic logic split_chan(input int ch);
    split_chan = (ch == 1) || (ch == 3);
  endfunction

  function automatic logic pick_tick(input logic [1:0] sel, input logic [3:0] pt, input int ch);
    pick_tick = 1'b0;
    if (split_chan(ch)) begin
      case (sel)
        CKS_A: pick_tick = pt[0];
        CKS_B: pick_tick = pt[1];
        CKS_C: pick_tick = pt[2];
        CKS_D: pick_tick = pt[3];
        default: pick_tick = 1'b0;
      endcase
    end else begin
      // clocks c and d do not exist here; low select bit ignored
      pick_tick = sel[1] ? pt[1] : pt[0];
    end
  endfunction

  function automatic logic [15:0] width_mask(input logic [15:0] md, input int ch);
    width_mask = (split_chan(ch) && md[F_MS]) ? SPLIT_MASK : FULL_MASK;
  endfunction

  // ==========================================================
  // bus decode
  always_comb begin
    rgn = addr[7:5];
    idx = addr[4:2];
    aligned = (addr[1:0] == 2'h0);
    outval_wr = wr_en && (addr == A_OUTVAL);
  end

  // ==========================================================
  // prescaler, counters, registers
  always_comb begin
    next_s = s;
    next_s.irq = '0;
    next_s.cen = '0;
    next_s.rdata = '0;
    next_s.pre_cnt = s.pre_cnt + 16'h0001;
    cmask = FULL_MASK;
    for (int k = 0; k < 4; k++) begin
      pre_tick[k] = &(s.pre_cnt | ~div_mask(s.pre_cfg[4*k +: 4]));
    end
    // count logic reads no output register
    for (int i = 0; i < NCH; i++) begin
      tick[i] = pick_tick(s.mode[i][F_CKS +: 2], pre_tick, i);
      cmask = width_mask(s.mode[i], i);
      next_s.cen[i] = tick[i];
      if (s.run[i] && tick[i]) begin
        if (s.mode[i][F_MD +: 3] != MD_INTERVAL) begin
          next_s.pend[i] = 1'b0;
        end else if (s.pend[i]) begin
          next_s.count[i] = s.reload[i] & cmask;
          next_s.pend[i] = 1'b0;
          next_s.irq[i] = s.mode[i][F_MD0];
        end else if ((s.count[i] & cmask) == 16'h0000) begin
          next_s.count[i] = s.reload[i] & cmask;
          next_s.irq[i] = 1'b1;
        end else begin
          next_s.count[i] = (s.count[i] - 16'h0001) & cmask;
        end
      end
    end
    if (wr_en && aligned) begin
      if (rgn == A_MODE[7:5]) begin
        next_s.mode[idx] = wr_data[15:0];
      end else if (rgn == A_RELOAD[7:5]) begin
        next_s.reload[idx] = wr_data[15:0];
      end else begin
        case (addr)
          A_OUTEN: next_s.oe = wr_data[NCH-1:0];
          A_POL: next_s.pol = wr_data[NCH-1:0];
          A_SLV: next_s.slv = wr_data[NCH-1:0];
          A_PRE: next_s.pre_cfg = wr_data[15:0];
          A_START: begin
            next_s.run = s.run | wr_data[NCH-1:0];
            next_s.pend = next_s.pend | wr_data[NCH-1:0];
          end
          A_STOP: begin
            next_s.run = s.run & ~wr_data[NCH-1:0];
            next_s.pend = next_s.pend & ~wr_data[NCH-1:0];
          end
          default: next_s.run = s.run;
        endcase
      end
    end
    if (rd_en && aligned) begin
      if (rgn == A_MODE[7:5]) begin
        next_s.rdata = {16'h0000, s.mode[idx]};
      end else if (rgn == A_RELOAD[7:5]) begin
        next_s.rdata = {16'h0000, s.reload[idx]};
      end else if (rgn == A_COUNT[7:5]) begin
        next_s.rdata = {16'h0000, s.count[idx]};
      end else begin
        case (addr)
          A_OUTVAL: next_s.rdata = {24'h000000, chan_pin_out};
          A_OUTEN: next_s.rdata = {24'h000000, s.oe};
          A_POL: next_s.rdata = {24'h000000, s.pol};
          A_SLV: next_s.rdata = {24'h000000, s.slv};
          A_RUN: next_s.rdata = {24'h000000, s.run};
          A_PRE: next_s.rdata = {16'h0000, s.pre_cfg};
          default: next_s.rdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s.mode <= {NCH{RST_MODE}};
      s.reload <= {NCH{RST_RELOAD}};
      s.count <= {NCH{RST_COUNT}};
      s.pre_cfg <= RST_PRE;
      s.pre_cnt <= 16'h0000;
      s.oe <= RST_BITS;
      s.pol <= RST_BITS;
      s.slv <= RST_BITS;
      s.run <= RST_BITS;
      s.pend <= RST_BITS;
      s.irq <= RST_BITS;
      s.cen <= RST_BITS;
      s.rdata <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rd_data = s.rdata;
  assign chan_irq = s.irq;
  assign chan_running = s.run;

  // ==========================================================
  // pin output circuits; lead of channel p is nearest even below
  for (genvar p = 0; p < NCH; p++) begin : g_out
    localparam int M = (p % 2 == 1) ? p - 1 : p - 2;
    logic m_irq;
    if (p == 0) begin : g_nolead
      assign m_irq = 1'b0;
    end else begin : g_lead
      assign m_irq = s.irq[M];
    end
    tco_chan_out u_out (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .oe(s.oe[p]),
      .slave_sel(s.slv[p]),
      .polarity(s.pol[p]),
      .own_irq(s.irq[p]),
      .master_irq(m_irq),
      .cen(s.cen[p]),
      .wr_en(outval_wr),
      .wr_val(wr_data[p]),
      .pin(chan_pin_out[p])
    );
  end
endmodule

/* File: include/tco_pkg.sv */
// shared constants of the eight-channel timer with pin outputs
// assumes a word-aligned register port with 8-bit byte address
package tco_pkg;
  localparam int NCH = 8;
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int CW = 16;
  // ==========================================================
  // register map, byte addresses; regions of eight words
  localparam logic [7:0] A_MODE = 8'h00;
  localparam logic [7:0] A_RELOAD = 8'h20;
  localparam logic [7:0] A_COUNT = 8'h40;
  localparam logic [7:0] A_OUTVAL = 8'h60;
  localparam logic [7:0] A_OUTEN = 8'h64;
  localparam logic [7:0] A_POL = 8'h68;
  localparam logic [7:0] A_SLV = 8'h6C;
  localparam logic [7:0] A_START = 8'h70;
  localparam logic [7:0] A_STOP = 8'h74;
  localparam logic [7:0] A_RUN = 8'h78;
  localparam logic [7:0] A_PRE = 8'h7C;
  // ==========================================================
  // channel mode config fields
  localparam int F_CKS = 14;
  localparam int F_CCS = 12;
  localparam int F_MS = 11;
  localparam int F_STS = 8;
  localparam int F_CIS = 6;
  localparam int F_MD = 1;
  localparam int F_MD0 = 0;
  localparam logic [2:0] MD_INTERVAL = 3'h0;
  localparam logic [2:0] MD_CAPTURE = 3'h2;
  localparam logic [1:0] CKS_A = 2'h0;
  localparam logic [1:0] CKS_B = 2'h2;
  localparam logic [1:0] CKS_C = 2'h1;
  localparam logic [1:0] CKS_D = 2'h3;
  localparam logic [15:0] SPLIT_MASK = 16'h00FF;
  localparam logic [15:0] FULL_MASK = 16'hFFFF;
  // ==========================================================
  // reset values
  localparam logic [15:0] RST_MODE = 16'h0000;
  localparam logic [15:0] RST_RELOAD = 16'h0000;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [15:0] RST_PRE = 16'h0000;
  localparam logic [7:0] RST_BITS = 8'h00;
  localparam logic RST_PIN = 1'b0;
endpackage

/* File: logic/tco_chan_out.sv */
// one channel's pin output circuit: toggle or set/reset, software load
// assumes irq and cen pulses are one sys_clk cycle wide
`timescale 1ns/10ps
module tco_chan_out (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic oe,
  input wire logic slave_sel,
  input wire logic polarity,
  input wire logic own_irq,
  input wire logic master_irq,
  input wire logic cen,
  input wire logic wr_en,
  input wire logic wr_val,
  output logic pin
);
  import tco_pkg::*;

  typedef struct packed {
    logic pin;
    logic set_pend;
  } tco_out_t;

  tco_out_t s;
  tco_out_t next_s;
  logic set_now;

  // ==========================================================
  // output state
  always_comb begin
    next_s = s;
    set_now = 1'b0;
    if (oe) begin
      if (!slave_sel) begin
        next_s.set_pend = 1'b0;
        if (own_irq) begin
          next_s.pin = ~s.pin;
        end
      end else begin
        set_now = s.set_pend & cen;
        if (set_now) begin
          next_s.set_pend = 1'b0;
        end
        if (master_irq) begin
          next_s.set_pend = 1'b1;
        end
        // polarity sampled only when an edge happens
        if (own_irq) begin
          next_s.pin = polarity;
        end else if (set_now) begin
          next_s.pin = ~polarity;
        end
      end
    end else begin
      next_s.set_pend = 1'b0;
      if (wr_en) begin
        next_s.pin = wr_val;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s <= '{pin: RST_PIN, set_pend: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign pin = s.pin;
endmodule

/* File: verif/tco_timer_monitor.sv */
// checker of register port answers and channel run, read and irq relations
// assumes binding to tco_timer with one clock and an active-low async reset
`timescale 1ns/10ps
module tco_timer_chk #(
  parameter int CNT_W = 16
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [tco_pkg::AW-1:0] addr,
  input wire logic [tco_pkg::DW-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [tco_pkg::DW-1:0] rd_data,
  input wire logic [tco_pkg::NCH-1:0] chan_pin_out,
  input wire logic [tco_pkg::NCH-1:0] chan_irq,
  input wire logic [tco_pkg::NCH-1:0] chan_running
);
  import tco_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // read port
  idle_read_zero_a: assert property (!$past(rd_en) |-> rd_data == '0)
    else $error("read data not zero outside a read answer");
  pin_read_a: assert property (rd_en && addr == A_OUTVAL |=> rd_data == {24'h0, $past(chan_pin_out)})
    else $error("output value read differs from pins");
  run_read_a: assert property (rd_en && addr == A_RUN |=> rd_data == {24'h0, $past(chan_running)})
    else $error("run status read differs from run outputs");
  start_read_a: assert property (rd_en && addr == A_START |=> rd_data == '0)
    else $error("start register read not zero");
  unmapped_read_a: assert property (rd_en && addr == 8'h80 |=> rd_data == '0)
    else $error("unmapped read not zero");
  // ==========================================================
  // run control and interrupts
  start_runs_a: assert property (wr_en && addr == A_START |=>
    (chan_running & $past(wr_data[7:0])) == $past(wr_data[7:0]))
    else $error("started channel not running");
  stop_halts_a: assert property (wr_en && addr == A_STOP |=> (chan_running & $past(wr_data[7:0])) == 8'h00)
    else $error("stopped channel still running");
  irq_when_run_a: assert property ((chan_irq & ~$past(chan_running)) == 8'h00)
    else $error("interrupt from a channel not running");
endmodule

bind tco_timer tco_timer_chk #(.CNT_W(CNT_W)) i_tco_timer_chk (.sys_clk(sys_clk), .nrst(nrst), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .chan_pin_out(chan_pin_out),
  .chan_irq(chan_irq), .chan_running(chan_running));

/* File: verif/tco_timer_tb_top.sv */
// self-checking bench of the eight-channel timer with pin outputs
// assumes prescale reset value 0, so every channel ticks each cycle
`timescale 1ns/10ps
module tco_timer_tb_top;
  import tco_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [AW-1:0] addr = '0;
  logic [DW-1:0] wr_data = '0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [DW-1:0] rd_data;
  logic [NCH-1:0] chan_pin_out;
  logic [NCH-1:0] chan_irq;
  logic [NCH-1:0] chan_running;
  int fail_count = 0;
  int comparisons = 0;
  int gap = 0;
  int per = 0;
  tco_timer i_tco_timer (.sys_clk(sys_clk), .nrst(nrst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .chan_pin_out(chan_pin_out), .chan_irq(chan_irq),
    .chan_running(chan_running));
  always #12.5 sys_clk = ~sys_clk;
  // cycles between channel 0 interrupts; per settles one edge after an interrupt
  always @(posedge sys_clk) begin
    gap <= chan_irq[0] ? 1 : gap + 1;
    if (chan_irq[0]) per <= gap;
  end
  // ==========================================================
  // helpers
  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge sys_clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rdchk(input logic [AW-1:0] a, input logic [DW-1:0] e);
    @(posedge sys_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1;
    chk(rd_data, e);
  endtask
  task automatic pin_chk(input int k, input logic e);
    @(posedge sys_clk);
    #1;
    chk(chan_pin_out[k], e);
  endtask
  task automatic per_chk(input int e);
    @(posedge sys_clk);
    #1;
    chk(per, e);
  endtask
  task automatic wait_irq(input int k, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge sys_clk);
      #1;
      if (chan_irq[k] === 1'b1) return;
    end
    fail_count++;
    $display("wrong value at %0t: got %h expected %h", $time, 0, 1);
    results();
  endtask
  // ==========================================================
  // scenarios
  task automatic sc_reset();
    logic [7:0] al [6] = '{A_OUTVAL, A_OUTEN, A_RUN, A_MODE, A_RELOAD, 8'h80};
    wr(A_RUN, 32'hFF);
    foreach (al[i]) rdchk(al[i], 32'h0);
  endtask
  task automatic sc_collective();
    wr(A_OUTEN, 32'h0F);
    wr(A_OUTVAL, 32'hFF);
    rdchk(A_OUTVAL, 32'hF0);
    wr(A_OUTEN, 32'h00);
    wr(A_OUTVAL, 32'h00);
    rdchk(A_OUTVAL, 32'h00);
  endtask
  task automatic sc_interval();
    logic pe;
    pe = chan_pin_out[0];
    wr(A_RELOAD, 32'h7);
    wr(A_MODE, 32'h1);
    wr(A_OUTEN, 32'h1);
    wr(A_POL, 32'h1);
    wr(A_START, 32'h1);
    wait_irq(0, 4);
    pe = ~pe;
    pin_chk(0, pe);
    wait_irq(0, 12);
    per_chk(8);
    pe = ~pe;
    pin_chk(0, pe);
    wr(A_RELOAD, 32'h3);
    wr(A_OUTVAL, 32'hFF);
    pin_chk(0, pe);
    wait_irq(0, 12);
    per_chk(8);
    wait_irq(0, 12);
    per_chk(4);
    wr(A_STOP, 32'h1);
    rdchk(A_RUN, 32'h0);
    // clock a halved: one count clock every second cycle
    wr(A_PRE, 32'h1);
    wr(A_START, 32'h1);
    wait_irq(0, 4);
    wait_irq(0, 12);
    per_chk(8);
    wr(A_STOP, 32'h1);
    wr(A_PRE, 32'h0);
  endtask
  task automatic sc_start_bit();
    logic p3;
    p3 = chan_pin_out[3];
    wr(A_RELOAD + 8'h8, 32'h2);
    wr(A_MODE + 8'hC, 32'h9);
    wr(A_OUTEN, 32'h0C);
    wr(A_START, 32'h0C);
    for (int i = 0; i < 12; i++) begin
      @(posedge sys_clk);
      #1;
      chk(chan_irq[2], i > 0 && i % 3 == 0);
      chk(chan_irq[3], 1'b0);
    end
    wait_irq(2, 8);
    chk(chan_pin_out[3], p3);
    wr(A_STOP, 32'h0C);
  endtask
  task automatic sc_slave();
    wr(A_OUTEN, 32'h0);
    wr(A_OUTVAL, 32'h0);
    wr(A_POL, 32'h0);
    wr(A_SLV, 32'h2);
    wr(A_RELOAD + 8'h4, 32'hC8);
    // long slave period keeps the level write clear of slave interrupts
    wr(A_RELOAD, 32'hF);
    wr(A_OUTEN, 32'h3);
    wr(A_START, 32'h3);
    wait_irq(0, 12);
    pin_chk(1, 1'b0);
    repeat (1) @(posedge sys_clk);
    pin_chk(1, 1'b1);
    wr(A_POL, 32'h2);
    pin_chk(1, 1'b1);
    wait_irq(0, 12);
    repeat (2) @(posedge sys_clk);
    pin_chk(1, 1'b0);
    wait_irq(1, 200);
    pin_chk(1, 1'b1);
    wr(A_STOP, 32'hFF);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    sc_reset();
    sc_collective();
    sc_interval();
    sc_start_bit();
    sc_slave();
    results();
  end
endmodule
